// *** hw/adsq_ctrl.v ***
// What this block does
// - Resolve input into 1024 steps, ten bits
// - Fixed mode converts only selected channel
// - Scan ascends from input 0 to select
// - Channel select resets to zero
// - Unused analog pins stay readable port bits
// - Writing start bit one begins conversion
// - Busy set at start until finish
// - Single and repeat for fixed and scan
// - Mode comes from repeat and scan bits
// - Speed bit picks timing, resets high speed
// - Single end: done set, busy clear, irq
// - Repeat cleared: finish current, then stop
// - Each channel has own result, overwritten
// - Result registers are read-only
// - Reading any result clears done flag
// - Result left-justified across byte pair
//
// Purpose: Mode register, channel sequencing and result storage
// Assumes: Register access is a byte write/read port on ref_clk_in
// Notes:   Result reads use a channel index and byte select
`timescale 1ns/1ps
`include "adsq_map.vh"
module adsq_ctrl #(
   parameter [15:0] FAST_CYC = `ADSQ_FAST_CYC,
   parameter [15:0] SLOW_CYC = `ADSQ_SLOW_CYC
) (
   // Clock and reset
   input  wire        ref_clk_in,
   input  wire        sys_rst_in,
   // Mode register access
   input  wire        mode_wr_in,
   input  wire [7:0]  mode_wdata_in,
   output reg  [7:0]  conv_mode_reg_out,
   // Result access
   input  wire        res_rd_in,
   input  wire [1:0]  res_ch_in,
   input  wire        res_hi_in,
   output reg  [7:0]  res_rdata_out,
   // Events
   output reg         conv_done_irq_out,
   // Analog side
   output reg  [1:0]  mux_sel_out,
   output reg  [9:0]  dac_code_out,
   input  wire        cmp_hi_in,
   // Shared port
   input  wire [3:0]  analog_shared_port_in,
   output reg  [3:0]  port_rdata_out
);
   localparam ST_IDLE = 2'd0;
   localparam ST_CONV = 2'd1;
   localparam ST_WAIT = 2'd2;

   // Mode register fields
   reg  [1:0]  ch_sel_r;
   reg         speed_r;
   reg         scan_r;
   reg         repeat_r;
   // Sequencer state and its next values
   reg  [1:0]  state_r;
   reg  [1:0]  state_nxt;
   reg  [1:0]  cur_ch_r;
   reg  [1:0]  cur_ch_nxt;
   reg         busy_r;
   reg         busy_nxt;
   reg         done_r;
   reg         done_nxt;
   reg         go_r;
   reg         go_nxt;
   reg         irq_nxt;
   reg         store_nxt;
   // Conversion timing
   reg  [15:0] bit_cyc_r;
   reg  [15:0] bit_cyc_nxt;
   wire [15:0] total_cyc;
   wire [15:0] share_cyc;
   // Result storage and read path
   wire [3:0]  store_ch;
   wire [39:0] res_all;
   reg  [9:0]  sel_res;
   reg  [7:0]  rdata_nxt;
   genvar      g;
   // Converter engine and input synchronisers
   wire        sar_fin;
   wire [9:0]  sar_res;
   wire [9:0]  sar_dac;
   wire [3:0]  port_sync;
   reg         cmp_meta_r;
   reg         cmp_sync_r;
   // Decoded requests
   wire        start_wr;
   wire [1:0]  wr_ch;
   wire        last_ch;

   assign start_wr = mode_wr_in & mode_wdata_in[`ADSQ_START_BIT];
   assign wr_ch    = mode_wdata_in[`ADSQ_CH_MSB:`ADSQ_CH_LSB];
   assign last_ch  = !scan_r || (cur_ch_r == ch_sel_r);
   // Per-bit share of the selected conversion duration
   assign total_cyc = speed_r ? SLOW_CYC : FAST_CYC;
   assign share_cyc = total_cyc / `ADSQ_TRIALS;
   // One-hot slot select for the channel that just finished
   assign store_ch  = store_nxt ? (4'h1 << cur_ch_r) : 4'h0;

   // Trial-bit engine; its ladder code is registered again onto the pins
   adsq_sar u_sar (
      .ref_clk_in   (ref_clk_in),
      .sys_rst_in   (sys_rst_in),
      .go_in        (go_r),
      .bit_cyc_in   (bit_cyc_r),
      .fin_out      (sar_fin),
      .dac_code_out (sar_dac),
      .cmp_hi_in    (cmp_sync_r),
      .result_out   (sar_res)
   );

   // Shared port bits reach the read path through a two-flop synchroniser
   adsq_sync u_sync (
      .ref_clk_in (ref_clk_in),
      .sys_rst_in (sys_rst_in),
      .d_in       (analog_shared_port_in),
      .q_out      (port_sync)
   );

   // Comparator output is asynchronous to the clock
   // Two flops stand between it and the trial-bit engine
   always @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         cmp_meta_r <= 1'b0;
         cmp_sync_r <= 1'b0;
      end else begin
         cmp_meta_r <= cmp_hi_in;
         cmp_sync_r <= cmp_meta_r;
      end
   end

   // Mode fields; the start bit is a strobe and is not stored
   // Fields may change mid-run; the sequencer reads them at channel ends, while speed sets the per-bit time one clock later
   always @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         ch_sel_r <= `ADSQ_CH_RST;
         speed_r  <= 1'b0;
         scan_r   <= 1'b0;
         repeat_r <= 1'b0;
      end else if (mode_wr_in) begin
         ch_sel_r <= wr_ch;
         speed_r  <= mode_wdata_in[`ADSQ_SPEED_BIT];
         scan_r   <= mode_wdata_in[`ADSQ_SCAN_BIT];
         repeat_r <= mode_wdata_in[`ADSQ_REPEAT_BIT];
      end
   end

   // The comparator answer trails a trial code by three clocks, so
   // each trial bit gets at least the minimum number of clocks
   always @* begin
      if (share_cyc < `ADSQ_MIN_BIT_CYC)
         bit_cyc_nxt = `ADSQ_MIN_BIT_CYC;
      else
         bit_cyc_nxt = share_cyc;
   end

   // Per-bit time, registered to keep the divider off the engine path
   always @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in)
         bit_cyc_r <= `ADSQ_MIN_BIT_CYC;
      else
         bit_cyc_r <= bit_cyc_nxt;
   end

   // Sequencer: IDLE waits for a start write, WAIT gives the engine one
   // clock to take go, CONV waits for the engine to finish a channel
   always @* begin
      state_nxt  = state_r;
      cur_ch_nxt = cur_ch_r;
      busy_nxt   = busy_r;
      done_nxt   = done_r;
      go_nxt     = 1'b0;
      irq_nxt    = 1'b0;
      store_nxt  = 1'b0;
      // A read that collides with a new completion loses to the set
      if (res_rd_in)
         done_nxt = 1'b0;
      case (state_r)
         ST_IDLE: begin
            // A start while busy is ignored: only the idle state looks
            if (start_wr) begin
               busy_nxt  = 1'b1;
               done_nxt  = 1'b0;
               go_nxt    = 1'b1;
               state_nxt = ST_WAIT;
               if (mode_wdata_in[`ADSQ_SCAN_BIT])
                  cur_ch_nxt = 2'b00;
               else
                  cur_ch_nxt = wr_ch;
            end
         end
         ST_WAIT: begin
            // Engine sees go on this edge; fin cannot be pending
            state_nxt = ST_CONV;
         end
         ST_CONV: begin
            if (sar_fin) begin
               store_nxt = 1'b1;
               if (!last_ch) begin
                  cur_ch_nxt = cur_ch_r + 2'b01;
                  go_nxt     = 1'b1;
                  state_nxt  = ST_WAIT;
               end else if (repeat_r) begin
                  go_nxt    = 1'b1;
                  state_nxt = ST_WAIT;
                  if (scan_r)
                     cur_ch_nxt = 2'b00;
                  else
                     cur_ch_nxt = ch_sel_r;
               end else begin
                  // Single run, or repeat cleared: this was the last one
                  busy_nxt  = 1'b0;
                  done_nxt  = 1'b1;
                  irq_nxt   = 1'b1;
                  state_nxt = ST_IDLE;
               end
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // Sequencer registers
   always @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state_r           <= ST_IDLE;
         cur_ch_r          <= `ADSQ_CH_RST;
         busy_r            <= 1'b0;
         done_r            <= 1'b0;
         go_r              <= 1'b0;
         conv_done_irq_out <= 1'b0;
      end else begin
         state_r           <= state_nxt;
         cur_ch_r          <= cur_ch_nxt;
         busy_r            <= busy_nxt;
         done_r            <= done_nxt;
         go_r              <= go_nxt;
         conv_done_irq_out <= irq_nxt;
      end
   end

   // One result slot per channel, written only when that channel ends
   // Slots of channels outside the current run keep their old results
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_res
         reg [9:0] val_r;
         always @(posedge ref_clk_in or posedge sys_rst_in) begin
            if (sys_rst_in)
               val_r <= `ADSQ_RES_RST;
            else if (store_ch[g])
               val_r <= sar_res;
         end
         assign res_all[g*10 +: 10] = val_r;
      end
   endgenerate

   // Result read select; the low byte pads its unused bits with ones
   // Reading never feeds a slot, so the result registers are read-only
   always @* begin
      if (res_ch_in == 2'h0)
         sel_res = res_all[9:0];
      else if (res_ch_in == 2'h1)
         sel_res = res_all[19:10];
      else if (res_ch_in == 2'h2)
         sel_res = res_all[29:20];
      else
         sel_res = res_all[39:30];
      if (res_hi_in)
         rdata_nxt = sel_res[9:2];
      else
         rdata_nxt = {sel_res[1:0], `ADSQ_LO_FILL};
   end

   // Registered views; result registers have no write path
   // Pins show the internal state one clock later
   always @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         conv_mode_reg_out <= `ADSQ_MODE_RST;
         res_rdata_out     <= 8'h00;
         mux_sel_out       <= 2'b00;
         dac_code_out      <= 10'h000;
         port_rdata_out    <= 4'h0;
      end else begin
         conv_mode_reg_out <= {busy_r, done_r, repeat_r, scan_r, speed_r,
                               1'b0, ch_sel_r};
         res_rdata_out     <= rdata_nxt;
         mux_sel_out       <= cur_ch_r;
         dac_code_out      <= sar_dac;
         port_rdata_out    <= port_sync;
      end
   end
endmodule

// *** hw/adsq_sar.v ***
// Purpose: Successive-approximation step engine for one conversion
// Assumes: Comparator result is synchronous to ref_clk_in
// Notes:   Ten trial bits, each given an equal share of the duration
`timescale 1ns/1ps
`include "adsq_map.vh"
module adsq_sar (
   // Clock and reset
   input  wire        ref_clk_in,
   input  wire        sys_rst_in,
   // Control
   input  wire        go_in,
   input  wire [15:0] bit_cyc_in,
   output reg         fin_out,
   // Ladder and comparator
   output reg  [9:0]  dac_code_out,
   input  wire        cmp_hi_in,
   output reg  [9:0]  result_out
);
   reg [3:0]  bit_r;
   reg [15:0] cnt_r;
   reg        run_r;
   always @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         bit_r        <= 4'h0;
         cnt_r        <= 16'h0000;
         run_r        <= 1'b0;
         fin_out      <= 1'b0;
         dac_code_out <= 10'h000;
         result_out   <= 10'h000;
      end else begin
         fin_out <= 1'b0;
         if (go_in && !run_r) begin
            run_r        <= 1'b1;
            bit_r        <= 4'h9;
            cnt_r        <= 16'h0000;
            dac_code_out <= 10'h200;
         end else if (run_r) begin
            if (cnt_r + 16'h0001 >= bit_cyc_in) begin
               cnt_r <= 16'h0000;
               // Keep or drop the trial bit, then try the next one down
               if (!cmp_hi_in)
                  dac_code_out[bit_r] <= 1'b0;
               if (bit_r == 4'h0) begin
                  run_r      <= 1'b0;
                  fin_out    <= 1'b1;
                  result_out <= {dac_code_out[9:1],
                                 cmp_hi_in & dac_code_out[0]};
               end else begin
                  bit_r <= bit_r - 4'h1;
                  dac_code_out[bit_r - 4'h1] <= 1'b1;
               end
            end else begin
               cnt_r <= cnt_r + 16'h0001;
            end
         end
      end
   end
endmodule

// *** hw/adsq_sync.v ***
// Purpose: Two-flop synchroniser for the analog shared port bits
// Assumes: Inputs arrive asynchronously
// Notes:   First stage feeds only the second
`timescale 1ns/1ps
module adsq_sync (
   // Clock and reset
   input  wire       ref_clk_in,
   input  wire       sys_rst_in,
   // Data
   input  wire [3:0] d_in,
   output wire [3:0] q_out
);
   reg [3:0] meta_r;
   reg [3:0] sync_r;
   always @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         meta_r <= 4'h0;
         sync_r <= 4'h0;
      end else begin
         meta_r <= d_in;
         sync_r <= meta_r;
      end
   end
   assign q_out = sync_r;
endmodule

// *** pkg/adsq_map.vh ***
// Purpose: Field positions, reset values and timing for the converter control
// Assumes: 200 MHz system clock
// Notes:   Mode register is eight bits wide
`ifndef ADSQ_MAP_VH
`define ADSQ_MAP_VH

`define ADSQ_CH_LSB        0
`define ADSQ_CH_MSB        1
`define ADSQ_START_BIT     2
`define ADSQ_SPEED_BIT     3
`define ADSQ_SCAN_BIT      4
`define ADSQ_REPEAT_BIT    5
`define ADSQ_DONE_BIT      6
`define ADSQ_BUSY_BIT      7
`define ADSQ_MODE_RST      8'h00
`define ADSQ_STEPS         1024
`define ADSQ_RES_BITS      10
`define ADSQ_FAST_CYC      16'h0028
`define ADSQ_SLOW_CYC      16'h0050
`define ADSQ_CH_RST        2'h0
`define ADSQ_RES_RST       10'h000
`define ADSQ_TRIALS        16'h000a
`define ADSQ_MIN_BIT_CYC   16'h0004
`define ADSQ_LO_FILL       6'h3f

`endif

// *** verif/adsq_ana_model.sv ***
// Purpose: Analog multiplexer and ladder comparator model
// Assumes: Ideal comparator, the bench sets the four input levels
// Notes:   Output is high while the input is at or above the ladder
`timescale 1ns/1ps
module adsq_ana_model (
   // Input levels, channel 0 in the low bits
   input  wire [39:0] level_in,
   // Ladder side
   input  wire [1:0]  mux_sel_in,
   input  wire [9:0]  dac_code_in,
   output wire        cmp_hi_out
);
   wire [9:0] lvl;
   assign lvl = level_in[mux_sel_in*10 +: 10];
   assign cmp_hi_out = (lvl >= dac_code_in);
endmodule

// *** verif/adsq_ctrl_asserts.sv ***
// Purpose: Port checks for the converter control
// Assumes: One clock, asynchronous high reset
// Notes:   Bound by name to every instance
`timescale 1ns/1ps
module adsq_ctrl_chk (
   // Watched ports
   input wire       ref_clk_in,
   input wire       sys_rst_in,
   input wire       mode_wr_in,
   input wire [7:0] mode_wdata_in,
   input wire [7:0] conv_mode_reg_out,
   input wire       res_rd_in,
   input wire       conv_done_irq_out,
   input wire [3:0] analog_shared_port_in,
   input wire [3:0] port_rdata_out
);
   wire busy = conv_mode_reg_out[7];
   wire done = conv_mode_reg_out[6];
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (sys_rst_in);
   a_irq_one_cycle: assert property (
      conv_done_irq_out |=> !conv_done_irq_out) else $error("irq width");
   a_irq_sets_done: assert property (
      $rose(conv_done_irq_out) |-> ##[0:1] (done && !busy))
      else $error("irq without done");
   a_start_sets_busy: assert property (
      mode_wr_in && mode_wdata_in[2] && !busy |-> ##2 busy)
      else $error("start without busy");
   a_start_reads_zero: assert property (
      !conv_mode_reg_out[2]) else $error("start bit reads one");
   a_reset_clears: assert property (
      $fell(sys_rst_in) |-> conv_mode_reg_out == 8'h00)
      else $error("mode not cleared");
   a_single_ends: assert property (
      $rose(busy) && !conv_mode_reg_out[5] |-> ##[1:1000] !busy)
      else $error("busy stuck");
   a_read_clears: assert property (
      res_rd_in && !busy |-> ##[1:2] !done) else $error("done kept");
   a_port_follows: assert property (
      $stable(analog_shared_port_in)[*4] |->
      port_rdata_out == analog_shared_port_in) else $error("port bits");
endmodule
bind adsq_ctrl adsq_ctrl_chk chk (.ref_clk_in, .sys_rst_in, .mode_wr_in,
   .mode_wdata_in, .conv_mode_reg_out, .res_rd_in, .conv_done_irq_out,
   .analog_shared_port_in, .port_rdata_out);

// *** verif/adsq_ctrl_test.sv ***
// Purpose: Self-checking bench for the converter control
// Assumes: Ideal analog model, default conversion counts
// Notes:   Each scenario is a task of its own
`timescale 1ns/1ps
module adsq_ctrl_test;
   reg         clk = 1'b0;
   reg         rst = 1'b1;
   reg         wr = 1'b0;
   reg  [7:0]  wd = 8'h00;
   reg         rd = 1'b0;
   reg  [1:0]  rch = 2'h0;
   reg         rhi = 1'b0;
   reg  [3:0]  port = 4'h0;
   reg  [39:0] lvl = 40'h0;
   wire [7:0]  mode, rdata;
   wire        irq, cmp;
   wire [1:0]  mux;
   wire [9:0]  dac;
   wire [3:0]  pdata;
   integer     err_count = 0, num_checks = 0, irqs, cyc, fast, i;
   adsq_ctrl #(.FAST_CYC(16'h0028), .SLOW_CYC(16'h0050)) uut (
      .ref_clk_in(clk), .sys_rst_in(rst), .mode_wr_in(wr),
      .mode_wdata_in(wd), .conv_mode_reg_out(mode), .res_rd_in(rd),
      .res_ch_in(rch), .res_hi_in(rhi), .res_rdata_out(rdata),
      .conv_done_irq_out(irq), .mux_sel_out(mux), .dac_code_out(dac),
      .cmp_hi_in(cmp), .analog_shared_port_in(port),
      .port_rdata_out(pdata));
   adsq_ana_model ana (.level_in(lvl), .mux_sel_in(mux),
      .dac_code_in(dac), .cmp_hi_out(cmp));
   initial forever #2.5 clk = ~clk;
   function [9:0] lv(input [1:0] c);
      lv = lvl[c*10 +: 10];
   endfunction
   task check(input [9:0] seen, input [9:0] exp);
      begin
         num_checks = num_checks + 1;
         if (seen !== exp) begin
            err_count = err_count + 1;
            $display("BAD %0t saw %h want %h", $time, seen, exp);
         end
      end
   endtask
   task results;
      begin
         $display("checks %0d bad %0d", num_checks, err_count);
         if (err_count == 0 && num_checks > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask
   task mwr(input [7:0] d);
      begin
         @(posedge clk);
         wr <= 1'b1;
         wd <= d;
         @(posedge clk);
         wr <= 1'b0;
      end
   endtask
   task idle;
      begin
         irqs = 0;
         cyc = 0;
         repeat (3) begin
            @(negedge clk);
            irqs = irqs + irq;
         end
         while (cyc < 3000 && mode[7] !== 1'b0) begin
            @(negedge clk);
            irqs = irqs + irq;
            cyc = cyc + 1;
         end
         repeat (3) begin
            @(negedge clk);
            irqs = irqs + irq;
         end
         check(cyc < 3000, 1);
         if (cyc >= 3000)
            results;
      end
   endtask
   task cres(input [1:0] ch, input [9:0] v);
      begin
         @(posedge clk);
         rch <= ch;
         rhi <= 1'b1;
         rd <= 1'b1;
         @(posedge clk);
         rhi <= 1'b0;
         @(negedge clk);
         check(rdata, v[9:2]);
         @(posedge clk);
         rd <= 1'b0;
         @(negedge clk);
         check(rdata, {v[1:0], 6'h3f});
         check(mode[6], 0);
      end
   endtask
   task t_reset;
      begin
         check(mode, 8'h00);
         check(mode[3], 0);
         @(posedge clk);
         port <= 4'ha;
         repeat (5) @(negedge clk);
         check(pdata, 4'ha);
         $display("reset test done");
      end
   endtask
   task t_fixed;
      begin
         @(posedge clk);
         lvl <= {10'h2d3, 10'h0ff, 10'h200, 10'h3fe};
         for (i = 0; i < 4; i = i + 1) begin
            mwr({6'h01, i[1:0]});
            idle;
            check(irqs, 1);
            check(mode[7:6], 2'b01);
            cres(i[1:0], lv(i[1:0]));
         end
         fast = cyc;
         lvl <= {10'h123, 10'h256, 10'h089, 10'h301};
         mwr(8'h0e);
         idle;
         check(cyc > fast, 1);
         cres(2'h2, 10'h256);
         cres(2'h0, 10'h3fe);
         $display("fixed test done");
      end
   endtask
   task t_scan;
      begin
         @(posedge clk);
         lvl <= {10'h011, 10'h1c7, 10'h38e, 10'h0aa};
         mwr(8'h15);
         idle;
         check(irqs, 1);
         cres(2'h1, 10'h38e);
         cres(2'h3, 10'h2d3);
         mwr(8'h17);
         idle;
         for (i = 0; i < 4; i = i + 1)
            cres(i[1:0], lv(i[1:0]));
         $display("scan test done");
      end
   endtask
   task t_repeat;
      begin
         mwr(8'h35);
         irqs = 0;
         repeat (300) begin
            @(negedge clk);
            irqs = irqs + irq;
         end
         check(irqs, 0);
         check(mode[7], 1);
         @(posedge clk);
         lvl <= {10'h011, 10'h1c7, 10'h3c3, 10'h05a};
         repeat (300) @(negedge clk);
         mwr(8'h11);
         idle;
         check(irqs, 1);
         cres(2'h0, 10'h05a);
         cres(2'h1, 10'h3c3);
         $display("repeat test done");
      end
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      t_reset;
      t_fixed;
      t_scan;
      t_repeat;
      results;
   end
endmodule
